// [spf_pkg.sv]
// Purpose: Shared constants for the strap and pin function select block.
// Assumes: System clock of 125 MHz.
// Notes: Strap counts are in system clock cycles.
package spf_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned STRAP_SETTLE_NS = 100;
  localparam int unsigned STRAP_SETTLE_CYC =
    (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic REG_DISABLE_RST = 1'b0;
  localparam logic IRQ_MODE_RST = 1'b1;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPF_SAMPLE = 2'b00,
    SPF_SETTLE = 2'b01,
    SPF_RUN = 2'b10
  } spf_state_type;
endpackage

// [spf_sync.sv]
// Purpose: Three-stage synchroniser with agreement filter for a pin.
// Assumes: Input is asynchronous to clk.
// Notes: The first stage feeds only the second.
module spf_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once the second and third stages agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_out <= RST_VAL;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end
endmodule

// [spf_strap_pin_select.sv]
// Purpose: Strap sampling and function select of the dual-purpose pins.
// Assumes: rst_n is the power-on reset; sys_rst_n combines it with the external reset pin.
// Notes: Straps are caught after reset release and held until reset.
//
// Operation
// - Sample regulator strap during power-on sequence; the code samples it on every reset.
// - Regulator strap high disables core regulator.
// - Regulator strap low or floating enables regulator.
// - Sample interrupt strap on every reset.
// - Interrupt strap high selects interrupt output.
// - Interrupt strap low selects reference clock.
// - Pending interrupt drives shared pin low.
// - Reference clock mode outputs 50MHz clock.
// - External reset input is active low.
// - After strapping, regulator pin shows activity.
// - After strapping, interrupt strap pin shows speed.
// - Management uses external clock, bidirectional data.
module spf_strap_pin_select #(
  parameter int unsigned SETTLE_CYC = spf_pkg::STRAP_SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic external_reset_n,
  // 50 MHz clock from the crystal oscillator path
  input wire logic ref_clock_50m,
  // Regulator strap and activity indicator pin
  input wire logic regulator_disable_strap_i,
  output logic regulator_disable_strap_o,
  output logic regulator_disable_strap_oe,
  // Interrupt select strap and speed indicator pin
  input wire logic irq_pin_select_strap_i,
  output logic irq_pin_select_strap_o,
  output logic irq_pin_select_strap_oe,
  // Indicator sources from the core
  input wire logic activity_indicator,
  input wire logic speed_indicator,
  // Interrupt source from the core
  input wire logic irq_pending,
  // Shared interrupt or reference clock pin
  output logic irq_out_n_o,
  output logic irq_out_n_oe,
  // Configuration results
  output logic core_regulator_enable,
  output logic ref_clock_mode,
  output logic strap_done,
  // Management pins
  input wire logic mgmt_clock_in,
  input wire logic mgmt_data_i,
  input wire logic mgmt_data_drive,
  input wire logic mgmt_data_out,
  output logic mgmt_data_o,
  output logic mgmt_data_oe,
  output logic mgmt_clock_sync,
  output logic mgmt_data_sync
);
  import spf_pkg::*;

  // ----------------------------------------------------------------
  // Reset combination
  // ----------------------------------------------------------------
  logic sys_rst_n;
  assign sys_rst_n = rst_n & external_reset_n;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic reg_strap_lvl;
  logic irq_strap_lvl;

  spf_sync #(.RST_VAL(REG_DISABLE_RST)) u_sync_reg (
    .clk(clk),
    .rst_n(sys_rst_n),
    .pin_in(regulator_disable_strap_i),
    .level_out(reg_strap_lvl)
  );

  spf_sync #(.RST_VAL(IRQ_MODE_RST)) u_sync_irq (
    .clk(clk),
    .rst_n(sys_rst_n),
    .pin_in(irq_pin_select_strap_i),
    .level_out(irq_strap_lvl)
  );

  spf_sync #(.RST_VAL(1'b0)) u_sync_mdc (
    .clk(clk),
    .rst_n(sys_rst_n),
    .pin_in(mgmt_clock_in),
    .level_out(mgmt_clock_sync)
  );

  spf_sync #(.RST_VAL(1'b1)) u_sync_mdio (
    .clk(clk),
    .rst_n(sys_rst_n),
    .pin_in(mgmt_data_i),
    .level_out(mgmt_data_sync)
  );

  // ----------------------------------------------------------------
  // Strap sequencer
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = $clog2(SETTLE_CYC + SYNC_STAGES + 2);
  localparam logic [CNT_W-1:0] CNT_LAST =
    CNT_W'(SETTLE_CYC + SYNC_STAGES);

  spf_state_type state_q;
  logic [CNT_W-1:0] cnt_q;

  // Wait for the pins to settle through the synchronisers, then latch.
  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      state_q <= SPF_SAMPLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        SPF_SAMPLE: begin
          cnt_q <= '0;
          state_q <= SPF_SETTLE;
        end
        SPF_SETTLE: begin
          if (cnt_q == CNT_LAST) begin
            state_q <= SPF_RUN;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        SPF_RUN: begin
          state_q <= SPF_RUN;
        end
        default: begin
          state_q <= SPF_SAMPLE;
        end
      endcase
    end
  end

  logic latch_now;
  assign latch_now = (state_q == SPF_SETTLE) && (cnt_q == CNT_LAST);

  // ----------------------------------------------------------------
  // Strap latches
  // ----------------------------------------------------------------
  logic reg_disable_q;
  logic irq_mode_q;

  // Latched once per reset; indicator drive later cannot change them.
  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      reg_disable_q <= REG_DISABLE_RST;
    end else if (latch_now) begin
      reg_disable_q <= reg_strap_lvl;
    end
  end

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      irq_mode_q <= IRQ_MODE_RST;
    end else if (latch_now) begin
      irq_mode_q <= irq_strap_lvl;
    end
  end

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      strap_done <= 1'b0;
    end else if (latch_now) begin
      strap_done <= 1'b1;
    end
  end

  assign core_regulator_enable = ~reg_disable_q;
  assign ref_clock_mode = ~irq_mode_q;

  // ----------------------------------------------------------------
  // Indicator outputs
  // ----------------------------------------------------------------
  logic act_q;
  logic spd_q;

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      act_q <= 1'b0;
      spd_q <= 1'b0;
    end else begin
      act_q <= activity_indicator;
      spd_q <= speed_indicator;
    end
  end

  // Pins stay released while straps are read.
  assign regulator_disable_strap_o = act_q;
  assign regulator_disable_strap_oe = strap_done;
  assign irq_pin_select_strap_o = spd_q;
  assign irq_pin_select_strap_oe = strap_done;

  // ----------------------------------------------------------------
  // Shared interrupt or reference clock pin
  // ----------------------------------------------------------------
  logic irq_q;

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_pending & strap_done;
    end
  end

  // Interrupt mode is open drain: low when pending, else an external
  // pull-up holds the line high. The clock passes straight through.
  always_comb begin
    if (strap_done && ref_clock_mode) begin
      irq_out_n_o = ref_clock_50m;
      irq_out_n_oe = 1'b1;
    end else begin
      irq_out_n_o = 1'b0;
      irq_out_n_oe = irq_q;
    end
  end

  // ----------------------------------------------------------------
  // Management data pad
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      mgmt_data_o <= 1'b0;
      mgmt_data_oe <= 1'b0;
    end else begin
      mgmt_data_o <= mgmt_data_out;
      mgmt_data_oe <= mgmt_data_drive;
    end
  end
endmodule

// [spf_props.sv]
// Purpose: Port checker of the strap select block.
// Assumes: Both resets are active low and asynchronous.
// Notes: Bound to the block below the module.
module spf_props #(
  parameter int unsigned SETTLE_CYC = 13
) (
  // Clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic external_reset_n,
  input wire logic ref_clock_50m,
  // Pins and core sources
  input wire logic regulator_disable_strap_i,
  input wire logic irq_pin_select_strap_i,
  input wire logic activity_indicator,
  input wire logic speed_indicator,
  input wire logic irq_pending,
  input wire logic mgmt_data_drive,
  // Outputs
  input wire logic regulator_disable_strap_o,
  input wire logic regulator_disable_strap_oe,
  input wire logic irq_pin_select_strap_o,
  input wire logic irq_pin_select_strap_oe,
  input wire logic irq_out_n_o,
  input wire logic irq_out_n_oe,
  input wire logic core_regulator_enable,
  input wire logic ref_clock_mode,
  input wire logic strap_done,
  input wire logic mgmt_data_oe
);
  localparam int LO = SETTLE_CYC + 3;
  localparam int HI = SETTLE_CYC + 5;
  wire logic rst_all_n = rst_n & external_reset_n;
  logic [7:0] cnt_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_all_n);
  // Counts edges since the last release of either reset.
  always_ff @(posedge clk or negedge rst_all_n) begin
    if (!rst_all_n) cnt_q <= 8'h00;
    else if (cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
  end
  sequence s_latch;
    $rose(strap_done);
  endsequence
  sequence s_held;
    strap_done && $past(strap_done);
  endsequence
  latch_time_a: assert property (s_latch |-> cnt_q >= LO && cnt_q <= HI)
    else $error("strap latch at wrong cycle");
  strap_map_a: assert property (s_latch |->
    core_regulator_enable == !$past(regulator_disable_strap_i) &&
    ref_clock_mode == !$past(irq_pin_select_strap_i))
    else $error("strap levels mapped wrongly");
  latch_hold_a: assert property (s_held |->
    $stable(core_regulator_enable) && $stable(ref_clock_mode))
    else $error("latched straps changed");
  done_stays_a: assert property (strap_done |=> strap_done)
    else $error("strap done dropped");
  early_quiet_a: assert property (!strap_done |->
    !regulator_disable_strap_oe && !irq_pin_select_strap_oe &&
    !irq_out_n_oe)
    else $error("strap pin driven early");
  act_pin_a: assert property (s_held |-> regulator_disable_strap_oe &&
    regulator_disable_strap_o == $past(activity_indicator))
    else $error("activity pin wrong");
  speed_pin_a: assert property (s_held |-> irq_pin_select_strap_oe &&
    irq_pin_select_strap_o == $past(speed_indicator))
    else $error("speed pin wrong");
  irq_drive_a: assert property (s_held ##0 !ref_clock_mode |->
    !irq_out_n_o && irq_out_n_oe == $past(irq_pending))
    else $error("interrupt pin wrong");
  clk_out_a: assert property (ref_clock_mode |->
    irq_out_n_oe && irq_out_n_o == ref_clock_50m)
    else $error("clock pin wrong");
  mgmt_oe_a: assert property ($past(rst_all_n) |->
    mgmt_data_oe == $past(mgmt_data_drive))
    else $error("management drive wrong");
endmodule

bind spf_strap_pin_select spf_props #(.SETTLE_CYC(SETTLE_CYC)) i_props (
  .clk(clk),
  .rst_n(rst_n),
  .external_reset_n(external_reset_n),
  .ref_clock_50m(ref_clock_50m),
  .regulator_disable_strap_i(regulator_disable_strap_i),
  .irq_pin_select_strap_i(irq_pin_select_strap_i),
  .activity_indicator(activity_indicator),
  .speed_indicator(speed_indicator),
  .irq_pending(irq_pending),
  .mgmt_data_drive(mgmt_data_drive),
  .regulator_disable_strap_o(regulator_disable_strap_o),
  .regulator_disable_strap_oe(regulator_disable_strap_oe),
  .irq_pin_select_strap_o(irq_pin_select_strap_o),
  .irq_pin_select_strap_oe(irq_pin_select_strap_oe),
  .irq_out_n_o(irq_out_n_o),
  .irq_out_n_oe(irq_out_n_oe),
  .core_regulator_enable(core_regulator_enable),
  .ref_clock_mode(ref_clock_mode),
  .strap_done(strap_done),
  .mgmt_data_oe(mgmt_data_oe)
);

// [spf_board.sv]
// Purpose: Board resistors and wires around the block's pins.
// Assumes: A released pin shows its resistor level.
// Notes: The controller leaves the data line released.
module spf_board (
  // Strap resistor levels
  input wire logic reg_strap,
  input wire logic irq_strap,
  // Device drivers
  input wire logic act_o,
  input wire logic act_oe,
  input wire logic spd_o,
  input wire logic spd_oe,
  input wire logic irq_o,
  input wire logic irq_oe,
  input wire logic md_o,
  input wire logic md_oe,
  // Wire levels
  output logic act_pin,
  output logic spd_pin,
  output logic irq_pin,
  output logic md_pin
);
  assign act_pin = act_oe ? act_o : reg_strap;
  assign spd_pin = spd_oe ? spd_o : irq_strap;
  assign irq_pin = irq_oe ? irq_o : 1'b1;
  assign md_pin = md_oe ? md_o : 1'b1;
endmodule

// [strap_and_pin_function_select_bench.sv]
// Purpose: Self-checking bench of the strap select block.
// Assumes: Inputs other than the reference clock change at the falling clock edge.
// Notes: Both reset kinds and all strap pairs are run.
module strap_and_pin_function_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SC = 1;
  logic clk = 1'b0, rst_n = 1'b0, external_reset_n = 1'b1, rc = 1'b0;
  logic act = 1'b0, spd = 1'b0, irq = 1'b0, mck = 1'b0;
  logic mdd = 1'b0, mdo = 1'b0, rs = 1'b0, is = 1'b0;
  wire logic a_o, a_oe, s_o, s_oe, i_o, i_oe, m_o, m_oe;
  wire logic a_p, s_p, i_p, m_p, reg_en, cmode, done, mcs, mds;
  int n_errors = 0, tests_run = 0, seed = 44881, n;
  always #4 clk = ~clk;
  // Offset keeps the reference clock edges away from the sampling edges.
  initial begin
    #1;
    forever #10 rc = ~rc;
  end
  spf_strap_pin_select #(.SETTLE_CYC(SC)) i_dut (.clk(clk),
    .rst_n(rst_n), .external_reset_n(external_reset_n),
    .ref_clock_50m(rc), .regulator_disable_strap_i(a_p),
    .regulator_disable_strap_o(a_o), .regulator_disable_strap_oe(a_oe),
    .irq_pin_select_strap_i(s_p), .irq_pin_select_strap_o(s_o),
    .irq_pin_select_strap_oe(s_oe), .activity_indicator(act),
    .speed_indicator(spd), .irq_pending(irq), .irq_out_n_o(i_o),
    .irq_out_n_oe(i_oe), .core_regulator_enable(reg_en),
    .ref_clock_mode(cmode), .strap_done(done), .mgmt_clock_in(mck),
    .mgmt_data_i(m_p), .mgmt_data_drive(mdd), .mgmt_data_out(mdo),
    .mgmt_data_o(m_o), .mgmt_data_oe(m_oe), .mgmt_clock_sync(mcs),
    .mgmt_data_sync(mds));
  spf_board i_board (.reg_strap(rs), .irq_strap(is), .act_o(a_o),
    .act_oe(a_oe), .spd_o(s_o), .spd_oe(s_oe), .irq_o(i_o),
    .irq_oe(i_oe), .md_o(m_o), .md_oe(m_oe), .act_pin(a_p),
    .spd_pin(s_p), .irq_pin(i_p), .md_pin(m_p));
  task automatic check(input string nm, input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    logic [31:0] r;
    logic er, em;
    for (int k = 0; k < 8; k++) begin
      {rs, is} = k[1:0];
      if (k[2]) external_reset_n = 1'b0;
      else rst_n = 1'b0;
      repeat (4) @(negedge clk);
      check("reset done", done, 1'b0);
      check("regulator strap released", a_p, rs);
      check("interrupt strap released", s_p, is);
      check("shared pin released", i_p, 1'b1);
      rst_n = 1'b1;
      external_reset_n = 1'b1;
      n = 0;
      while (done !== 1'b1 && n < 50) begin
        @(negedge clk);
        n++;
      end
      check("latch cycles", n == SC + 5, 1'b1);
      er = !rs;
      em = !is;
      check("regulator enable", reg_en, er);
      check("clock mode", cmode, em);
      repeat (20) begin
        r = $random(seed);
        {act, spd, irq, mck, mdd, mdo} = r[5:0];
        @(negedge clk);
        check("activity pin", a_p, act);
        check("speed pin", s_p, spd);
        check("shared pin", i_p, em ? rc : !irq);
        check("data line", m_p, mdd ? mdo : 1'b1);
        check("latched regulator", reg_en, er);
        check("latched mode", cmode, em);
      end
      mck = r[6];
      mdd = 1'b1;
      mdo = r[7];
      repeat (6) @(negedge clk);
      check("clock sync", mcs, mck);
      check("data sync", mds, mdo);
    end
    complete_run();
  end
  initial begin
    #20000;
    n_errors++;
    complete_run();
  end
endmodule
